// ### verilog/rdpc_reset_debug_pins.sv
// Summary of operation
// (R1) power-on leaves shared reset pin as port
// (R2) reset_pin_select turns pin into sticky reset
// (R3) reset pin low resets the whole device
// (R4) reset function forces its pullup on
// (R5) pin reset always returns to user mode
// (R6) mode pin sampled during power-on/forced reset
// (R7) debug function on pin after every reset
// (R8) every reset sets debug_pin_select
// (R9) debug_pin_select forces debug pin pullup
// (R10) mode pin high gives normal mode
// (R11) mode pin low gives active background mode
// (R12) forced reset with pin low enters halt
// (R13) debug bit lasts sixteen clock cycles
// (R14) irq function pullup follows irq_pull_disable
// (R15) keypad edge select turns pullup into pulldown
// (R16) two-wire pins default, relocatable by software
// (R17) option registers run on the bus clock
// (R18) mode flag captured at internal reset release
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module rdpc_reset_debug_pins #(
   parameter int RST_HOLD_CYCLES = rdpc_pkg::RST_HOLD_CYCLES,
   parameter int BIT_CYCLES = rdpc_pkg::BIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_pa5_pin,
   input wire logic i_pa4_pin,
   input wire logic i_dctl_out,
   input wire logic i_dctl_oe,
   input wire logic i_pa4_port_out,
   input wire logic i_pa4_port_oe,
   output logic o_pa4_out,
   output logic o_pa4_oe,
   output rdpc_pkg::rdpc_pull_t o_pull,
   output rdpc_pkg::rdpc_pin_fn_t o_pin_fn,
   output logic o_irq_level,
   output logic o_int_rst_n,
   output logic o_halt_mode,
   output logic o_dbg_bit_sample,
   output logic o_dbg_bit_end,
   output logic o_dbg_rx_bit
);
   localparam int HCW = $clog2(RST_HOLD_CYCLES + 1);
   localparam logic [HCW-1:0] HOLD_LAST = HCW'(RST_HOLD_CYCLES - 1);
   localparam logic [HCW-1:0] HOLD_ONE = HCW'(1);
   localparam int KW = rdpc_pkg::KEY_PINS;
   localparam int PW = rdpc_pkg::PA_PINS;

   // address match, shared by the read and write paths
   function automatic logic addr_is(input logic [rdpc_pkg::ADDR_W-1:0] a, input logic [7:0] ofs);
      addr_is = (a == ofs);
   endfunction

   rdpc_pkg::rdpc_rst_state_t state;
   rdpc_pkg::rdpc_cause_t cause;
   logic [HCW-1:0] hold_cnt;
   logic int_rst;
   logic release_now;
   logic pin_rst_req;
   logic force_req;

   logic reset_pin_select;
   logic debug_pin_select;
   logic irq_pin_select;
   logic irq_pull_disable;
   logic two_wire_pin_relocate;
   logic [PW-1:0] pull_en;
   logic [KW-1:0] keypad_pin_enable;
   logic [KW-1:0] keypad_edge_select;

   logic dp_valid;
   logic dp_write;
   logic [rdpc_pkg::ADDR_W-1:0] dp_addr;
   logic ap_take;
   logic wr_ok;
   logic [31:0] next_rdata;

   logic mode_sel_fn;
   logic [PW-1:0] next_pull_up;
   logic [PW-1:0] next_pull_dn;
   logic pin_prev;
   logic bit_start;
   logic bit_busy;
   logic bit_sample;

   // zero-wait slave, always okay
   assign o_hreadyout = 1'b1;
   assign o_hresp = rdpc_pkg::HRESP_OKAY;

   // address phase: only word transfers are taken
   assign ap_take = i_hsel && i_htrans[1] && i_hready && (i_hsize == rdpc_pkg::HSIZE_WORD);

   // data phase bookkeeping, bus clock domain [R17]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else if (i_hready) begin
         dp_valid <= ap_take;
         dp_write <= i_hwrite;
         dp_addr <= i_haddr[rdpc_pkg::ADDR_W-1:0];
      end
   end

   // writes land in the data phase, none while internal reset holds
   assign wr_ok = dp_valid && dp_write && !int_rst;

   // reset pin low while selected as reset input [R3]
   assign pin_rst_req = reset_pin_select && !i_pa5_pin;
   assign int_rst = (state == rdpc_pkg::ST_HOLD);
   assign release_now = int_rst && (hold_cnt == HOLD_LAST) && !pin_rst_req;

   // software writes 1 to request a forced reset [R12]
   assign force_req = wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_FORCE) && i_hwdata[rdpc_pkg::BIT_FORCE];

   // reset sequencer: hold internal reset, remember its source [R3]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= rdpc_pkg::ST_HOLD;
         hold_cnt <= '0;
         cause <= rdpc_pkg::CAUSE_POR;
      end else begin
         case (state)
            rdpc_pkg::ST_RUN: begin
               hold_cnt <= '0;
               if (pin_rst_req) begin
                  state <= rdpc_pkg::ST_HOLD;
                  cause <= rdpc_pkg::CAUSE_PIN; // [R3]
               end else if (force_req) begin
                  state <= rdpc_pkg::ST_HOLD;
                  cause <= rdpc_pkg::CAUSE_FORCE; // [R12]
               end
            end
            rdpc_pkg::ST_HOLD: begin
               if (pin_rst_req) begin
                  hold_cnt <= '0;
                  cause <= rdpc_pkg::CAUSE_PIN;
               end else if (release_now) begin
                  state <= rdpc_pkg::ST_RUN;
               end else begin
                  hold_cnt <= hold_cnt + HOLD_ONE;
               end
            end
            default: begin
               state <= rdpc_pkg::ST_HOLD;
               hold_cnt <= '0;
            end
         endcase
      end
   end

   assign o_int_rst_n = !int_rst;

   // mode flag caught once at release; pin reset never selects halt [R5] [R18]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_halt_mode <= 1'b0;
      end else if (release_now) begin
         // low gives background mode, high gives normal mode [R10] [R11] [R12]
         o_halt_mode <= (cause != rdpc_pkg::CAUSE_PIN) && !i_pa4_pin;
      end
   end

   // reset_pin_select: set by software, cleared only by power-on [R1] [R2]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         reset_pin_select <= rdpc_pkg::RST_OFF;
      end else if (wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_OPT_A) && i_hwdata[rdpc_pkg::BIT_RST_SEL]) begin
         reset_pin_select <= 1'b1; // [R2]
      end
   end

   // debug_pin_select: set by every reset, software may clear [R8]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         debug_pin_select <= rdpc_pkg::RST_DBG_SEL;
      end else if (int_rst) begin
         debug_pin_select <= rdpc_pkg::RST_DBG_SEL; // [R8]
      end else if (wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_OPT_A)) begin
         debug_pin_select <= i_hwdata[rdpc_pkg::BIT_DBG_SEL];
      end
   end

   // irq pin options
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_pin_select <= rdpc_pkg::RST_OFF;
         irq_pull_disable <= rdpc_pkg::RST_OFF;
      end else if (int_rst) begin
         irq_pin_select <= rdpc_pkg::RST_OFF;
         irq_pull_disable <= rdpc_pkg::RST_OFF;
      end else if (wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_OPT_A)) begin
         irq_pin_select <= i_hwdata[rdpc_pkg::BIT_IRQ_SEL];
         irq_pull_disable <= i_hwdata[rdpc_pkg::BIT_IRQ_PDD];
      end
   end

   // two-wire pin location, default on port_a_bit2/3 [R16]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         two_wire_pin_relocate <= rdpc_pkg::RST_OFF;
      end else if (int_rst) begin
         two_wire_pin_relocate <= rdpc_pkg::RST_OFF;
      end else if (wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_OPT_B)) begin
         two_wire_pin_relocate <= i_hwdata[rdpc_pkg::BIT_TWI_RELOC]; // [R16]
      end
   end

   // port pull enables
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pull_en <= '0;
      end else if (int_rst) begin
         pull_en <= '0;
      end else if (wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_PULL_EN)) begin
         pull_en <= i_hwdata[PW-1:0];
      end
   end

   // keypad enables and edge selects
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         keypad_pin_enable <= '0;
         keypad_edge_select <= '0;
      end else if (int_rst) begin
         keypad_pin_enable <= '0;
         keypad_edge_select <= '0;
      end else if (wr_ok && addr_is(dp_addr, rdpc_pkg::OFS_KEYPAD)) begin
         keypad_pin_enable <= i_hwdata[rdpc_pkg::KEY_EN_LSB +: KW];
         keypad_edge_select <= i_hwdata[rdpc_pkg::KEY_EDGE_LSB +: KW];
      end
   end

   // read mux, evaluated in the address phase
   always_comb begin
      next_rdata = rdpc_pkg::RDATA_ZERO;
      if (addr_is(i_haddr[rdpc_pkg::ADDR_W-1:0], rdpc_pkg::OFS_OPT_A)) begin
         next_rdata[rdpc_pkg::BIT_RST_SEL] = reset_pin_select;
         next_rdata[rdpc_pkg::BIT_DBG_SEL] = debug_pin_select;
         next_rdata[rdpc_pkg::BIT_IRQ_SEL] = irq_pin_select;
         next_rdata[rdpc_pkg::BIT_IRQ_PDD] = irq_pull_disable;
      end else if (addr_is(i_haddr[rdpc_pkg::ADDR_W-1:0], rdpc_pkg::OFS_OPT_B)) begin
         next_rdata[rdpc_pkg::BIT_TWI_RELOC] = two_wire_pin_relocate;
      end else if (addr_is(i_haddr[rdpc_pkg::ADDR_W-1:0], rdpc_pkg::OFS_PULL_EN)) begin
         next_rdata[PW-1:0] = pull_en;
      end else if (addr_is(i_haddr[rdpc_pkg::ADDR_W-1:0], rdpc_pkg::OFS_KEYPAD)) begin
         next_rdata[rdpc_pkg::KEY_EN_LSB +: KW] = keypad_pin_enable;
         next_rdata[rdpc_pkg::KEY_EDGE_LSB +: KW] = keypad_edge_select;
      end else if (addr_is(i_haddr[rdpc_pkg::ADDR_W-1:0], rdpc_pkg::OFS_STATUS)) begin
         next_rdata[rdpc_pkg::ST_HALT_BIT] = o_halt_mode;
         next_rdata[rdpc_pkg::ST_CAUSE_LSB +: 2] = cause;
         next_rdata[rdpc_pkg::ST_INRST_BIT] = int_rst;
      end
   end

   // read data registered for the data phase
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hrdata <= rdpc_pkg::RDATA_ZERO;
      end else if (ap_take && !i_hwrite) begin
         o_hrdata <= next_rdata;
      end
   end

   // mode-select only while a power-on or forced reset holds [R6]
   assign mode_sel_fn = int_rst && (cause != rdpc_pkg::CAUSE_PIN);

   // pin function map; reset beats irq beats port on the shared pin
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pin_fn <= '0;
      end else begin
         o_pin_fn.pa5_reset <= reset_pin_select; // [R1] [R2]
         o_pin_fn.pa5_irq <= !reset_pin_select && irq_pin_select;
         o_pin_fn.pa4_mode_sel <= mode_sel_fn; // [R6]
         o_pin_fn.pa4_debug <= !mode_sel_fn && debug_pin_select; // [R7]
         o_pin_fn.twi_alt <= two_wire_pin_relocate; // [R16]
      end
   end

   // irq input level seen by the interrupt logic
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_irq_level <= 1'b1;
      end else begin
         o_irq_level <= (!reset_pin_select && irq_pin_select) ? i_pa5_pin : 1'b1;
      end
   end

   // pull resolution for keypad-capable pins [R15]
   genvar g;
   generate
      for (g = 0; g < KW; g = g + 1) begin : g_key_pull
         always_comb begin
            next_pull_up[g] = pull_en[g] && !(keypad_pin_enable[g] && keypad_edge_select[g]);
            next_pull_dn[g] = pull_en[g] && keypad_pin_enable[g] && keypad_edge_select[g]; // [R15]
         end
      end
   endgenerate

   // debug pin pull forced on while debug function selected [R9]
   always_comb begin
      next_pull_dn[rdpc_pkg::PA4] = 1'b0;
      next_pull_up[rdpc_pkg::PA4] = debug_pin_select || mode_sel_fn || pull_en[rdpc_pkg::PA4]; // [R9]
   end

   // shared reset/irq pin pull: reset forces on, irq follows its bit [R4] [R14]
   always_comb begin
      next_pull_dn[rdpc_pkg::PA5] = 1'b0;
      if (reset_pin_select) begin
         next_pull_up[rdpc_pkg::PA5] = 1'b1; // [R4]
      end else if (irq_pin_select) begin
         next_pull_up[rdpc_pkg::PA5] = !irq_pull_disable; // [R14]
      end else begin
         next_pull_up[rdpc_pkg::PA5] = pull_en[rdpc_pkg::PA5];
      end
   end

   // pull controls registered towards the pads
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pull <= '0;
      end else begin
         o_pull.up <= next_pull_up;
         o_pull.dn <= next_pull_dn;
      end
   end

   // debug pin driver: controller while debug, port otherwise, never in mode-select
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pa4_out <= 1'b0;
         o_pa4_oe <= 1'b0;
      end else if (mode_sel_fn) begin
         o_pa4_out <= 1'b0;
         o_pa4_oe <= 1'b0; // [R6]
      end else if (debug_pin_select) begin
         o_pa4_out <= i_dctl_out; // [R7]
         o_pa4_oe <= i_dctl_oe;
      end else begin
         o_pa4_out <= i_pa4_port_out; // [R8]
         o_pa4_oe <= i_pa4_port_oe;
      end
   end

   // falling edge on the debug wire starts a bit time
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_prev <= 1'b1;
      end else begin
         pin_prev <= i_pa4_pin;
      end
   end

   assign bit_start = debug_pin_select && !int_rst && pin_prev && !i_pa4_pin && !bit_busy;

   // bit timer of sixteen debug clocks [R13]
   rdpc_bit_timer #(
      .BIT_CYCLES(BIT_CYCLES)
   ) rdpc_bit_timer_inst (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_start(bit_start),
      .o_busy(bit_busy),
      .o_sample(bit_sample),
      .o_bit_end(o_dbg_bit_end)
   );

   assign o_dbg_bit_sample = bit_sample;

   // received bit level taken at the mid-bit strobe [R13]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dbg_rx_bit <= 1'b1;
      end else if (bit_sample) begin
         o_dbg_rx_bit <= i_pa4_pin;
      end
   end

endmodule

// ### verilog/rdpc_pkg.sv
package rdpc_pkg;

   // register window
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_OPT_A = 8'h00;
   localparam logic [7:0] OFS_OPT_B = 8'h04;
   localparam logic [7:0] OFS_PULL_EN = 8'h08;
   localparam logic [7:0] OFS_KEYPAD = 8'h0c;
   localparam logic [7:0] OFS_FORCE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // system_option_reg_a fields
   localparam int BIT_RST_SEL = 0;
   localparam int BIT_DBG_SEL = 1;
   localparam int BIT_IRQ_SEL = 2;
   localparam int BIT_IRQ_PDD = 3;
   // option reg b fields
   localparam int BIT_TWI_RELOC = 0;
   // debug_force_reset_reg fields
   localparam int BIT_FORCE = 0;
   // keypad register fields
   localparam int KEY_EN_LSB = 0;
   localparam int KEY_EDGE_LSB = 8;
   // status register fields
   localparam int ST_HALT_BIT = 0;
   localparam int ST_CAUSE_LSB = 1;
   localparam int ST_INRST_BIT = 3;

   // reset values
   localparam logic RST_DBG_SEL = 1'b1;
   localparam logic RST_OFF = 1'b0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic HRESP_OKAY = 1'b0;

   // pin counts and positions
   localparam int PA_PINS = 6;
   localparam int KEY_PINS = 4;
   localparam int PA4 = 4;
   localparam int PA5 = 5;

   // timing counts
   localparam int BIT_CYCLES = 16;
   localparam int RST_HOLD_CYCLES = 8;

   typedef enum logic [1:0] {CAUSE_POR, CAUSE_PIN, CAUSE_FORCE} rdpc_cause_t;
   typedef enum logic {ST_RUN, ST_HOLD} rdpc_rst_state_t;

   typedef struct packed {
      logic [PA_PINS-1:0] up;
      logic [PA_PINS-1:0] dn;
   } rdpc_pull_t;

   typedef struct packed {
      logic pa5_reset;
      logic pa5_irq;
      logic pa4_mode_sel;
      logic pa4_debug;
      logic twi_alt;
   } rdpc_pin_fn_t;

endpackage

// ### verilog/rdpc_bit_timer.sv
`timescale 1ns/10ps
module rdpc_bit_timer #(
   parameter int BIT_CYCLES = rdpc_pkg::BIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_start,
   output logic o_busy,
   output logic o_sample,
   output logic o_bit_end
);
   localparam int CW = $clog2(BIT_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(BIT_CYCLES - 1);
   localparam logic [CW-1:0] MID = CW'(BIT_CYCLES / 2 - 1);
   localparam logic [CW-1:0] ONE = CW'(1);

   logic [CW-1:0] cnt;

   // one bit time of the debug wire, started by a falling edge
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_busy <= 1'b0;
         cnt <= '0;
      end else if (!o_busy) begin
         if (i_start) begin
            o_busy <= 1'b1;
            cnt <= '0;
         end
      end else begin
         if (cnt == LAST) begin
            o_busy <= 1'b0;
         end
         cnt <= cnt + ONE;
      end
   end

   // registered strobes: mid-bit sample and end of bit
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sample <= 1'b0;
         o_bit_end <= 1'b0;
      end else begin
         o_sample <= o_busy && (cnt == MID);
         o_bit_end <= o_busy && (cnt == LAST);
      end
   end
endmodule

// ### testbench/rdpc_reset_debug_pins_chk.sv
`timescale 1ns/10ps
module rdpc_reset_debug_pins_chk #(
   parameter int RST_HOLD_CYCLES = 8,
   parameter int BIT_CYCLES = 16
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_pa5_pin,
   input wire logic i_pa4_pin,
   input wire logic o_pa4_oe,
   input wire rdpc_pkg::rdpc_pull_t o_pull,
   input wire rdpc_pkg::rdpc_pin_fn_t o_pin_fn,
   input wire logic o_int_rst_n,
   input wire logic o_halt_mode,
   input wire logic o_dbg_bit_sample,
   input wire logic o_dbg_bit_end
);
   logic pin_src;
   logic force_ap;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // marks a pin-sourced internal reset, and a write address phase to the force register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_src <= 1'b0;
         force_ap <= 1'b0;
      end else begin
         pin_src <= (o_pin_fn.pa5_reset && !i_pa5_pin) || (pin_src && !o_int_rst_n);
         force_ap <= i_hsel && i_htrans[1] && i_hready && i_hwrite && (i_haddr[7:0] == rdpc_pkg::OFS_FORCE);
      end
   end
   sequence s_release;
      $rose(o_int_rst_n);
   endsequence
   sequence s_pin_low;
      o_pin_fn.pa5_reset && !i_pa5_pin;
   endsequence
   property p_pin_rst; s_pin_low |=> !o_int_rst_n; endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");
   property p_sticky; $past(o_pin_fn.pa5_reset) |-> o_pin_fn.pa5_reset; endproperty
   a_sticky: assert property (p_sticky) else $error("reset pin function dropped");
   property p_rst_pull; o_pin_fn.pa5_reset |-> o_pull.up[5]; endproperty
   a_rst_pull: assert property (p_rst_pull) else $error("reset pin pullup off");
   property p_user; pin_src ##0 s_release |-> !o_halt_mode; endproperty
   a_user: assert property (p_user) else $error("pin reset gave halt mode");
   property p_mode_sel; (!pin_src && !o_int_rst_n) [*3] |-> o_pin_fn.pa4_mode_sel && !o_pa4_oe; endproperty
   a_mode_sel: assert property (p_mode_sel) else $error("mode select not active");
   property p_dbg_after; s_release |=> o_pin_fn.pa4_debug && !o_pin_fn.pa4_mode_sel; endproperty
   a_dbg_after: assert property (p_dbg_after) else $error("debug function missing");
   property p_dbg_pull; o_pin_fn.pa4_debug |-> o_pull.up[4]; endproperty
   a_dbg_pull: assert property (p_dbg_pull) else $error("debug pin pullup off");
   property p_mode; !pin_src ##0 s_release |-> o_halt_mode == !$past(i_pa4_pin); endproperty
   a_mode: assert property (p_mode) else $error("wrong mode at release");
   property p_keep; o_int_rst_n && $past(o_int_rst_n) |-> $stable(o_halt_mode); endproperty
   a_keep: assert property (p_keep) else $error("mode changed while running");
   property p_force; force_ap && i_hwdata[0] && o_int_rst_n |-> ##[1:2] !o_int_rst_n; endproperty
   a_force: assert property (p_force) else $error("forced reset missed");
   property p_bit_span; o_dbg_bit_sample |-> ##8 o_dbg_bit_end; endproperty
   a_bit_span: assert property (p_bit_span) else $error("bit end misplaced");
   property p_bit_gap; o_dbg_bit_end |=> !o_dbg_bit_sample [*6]; endproperty
   a_bit_gap: assert property (p_bit_gap) else $error("bit sample too soon");
endmodule
bind rdpc_reset_debug_pins rdpc_reset_debug_pins_chk #(
   .RST_HOLD_CYCLES(RST_HOLD_CYCLES),
   .BIT_CYCLES(BIT_CYCLES)
) rdpc_reset_debug_pins_chk_inst (
   .i_clk, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .i_pa5_pin, .i_pa4_pin,
   .o_pa4_oe, .o_pull, .o_pin_fn, .o_int_rst_n, .o_halt_mode, .o_dbg_bit_sample, .o_dbg_bit_end
);

// ### testbench/rdpc_debug_pod.sv
`timescale 1ns/10ps
module rdpc_debug_pod (
   input wire logic i_clk,
   input wire logic i_mode_low,
   input wire logic i_bit_req,
   input wire logic i_bit_val,
   input wire logic i_pa4_out,
   input wire logic i_pa4_oe,
   input wire logic i_pull_up,
   output logic o_pa4
);
   logic [4:0] cnt = 5'h00;
   logic flt = 1'b0;
   logic low;
   // bit frame of sixteen cycles, floating level flips each cycle
   always_ff @(posedge i_clk) begin
      if (i_bit_req) begin
         cnt <= 5'h10;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
      flt <= ~flt;
   end
   // low start, released early for a one
   assign low = (cnt != 5'h00) && ((5'h10 - cnt) < (i_bit_val ? 5'h04 : 5'h0c));
   // wired level: target drive, pod pull-down, pullup, else floating
   assign o_pa4 = i_pa4_oe ? i_pa4_out : (i_mode_low || low) ? 1'b0 : i_pull_up ? 1'b1 : flt;
endmodule

// ### testbench/test_reset_debug_pin_config.sv
`timescale 1ns/10ps
module test_reset_debug_pin_config;
   logic i_clk, i_rstn, hsel, hwrite, hready, hresp, pa5, pa4, dctl_out, dctl_oe, port_out, port_oe;
   logic pa4_out, pa4_oe, irq_lvl, int_rst_n, halt, bsmp, bend, rxb, mode_low, bit_req, bit_val;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   rdpc_pkg::rdpc_pull_t pull;
   rdpc_pkg::rdpc_pin_fn_t fn;
   int errors = 0;
   int tests_run = 0;
   rdpc_reset_debug_pins rdpc_reset_debug_pins_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_pa5_pin(pa5),
      .i_pa4_pin(pa4), .i_dctl_out(dctl_out), .i_dctl_oe(dctl_oe), .i_pa4_port_out(port_out),
      .i_pa4_port_oe(port_oe), .o_pa4_out(pa4_out), .o_pa4_oe(pa4_oe), .o_pull(pull), .o_pin_fn(fn),
      .o_irq_level(irq_lvl), .o_int_rst_n(int_rst_n), .o_halt_mode(halt), .o_dbg_bit_sample(bsmp),
      .o_dbg_bit_end(bend), .o_dbg_rx_bit(rxb));
   rdpc_debug_pod rdpc_debug_pod_inst (.i_clk(i_clk), .i_mode_low(mode_low), .i_bit_req(bit_req),
      .i_bit_val(bit_val), .i_pa4_out(pa4_out), .i_pa4_oe(pa4_oe), .i_pull_up(pull.up[4]), .o_pa4(pa4));
   // bus clock
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer at the current hsize, read data lands in rd
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge i_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge i_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_rst();
      int n;
      n = 0;
      while (int_rst_n !== 1'b0 && n < 50) begin
         @(posedge i_clk);
         n++;
      end
      check(n < 50, 1);
      n = 0;
      while (int_rst_n !== 1'b1 && n < 200) begin
         @(posedge i_clk);
         n++;
      end
      tick(2);
      check(n < 200, 1);
   endtask
   task automatic final_report();
      $display("tests %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_por();
      i_rstn <= 1'b0;
      tick(2);
      i_rstn <= 1'b1;
      wait_rst();
      check(fn, 5'b00010);
      check({halt, pull}, {1'b0, 6'h10, 6'h00});
      ahb(1'b0, rdpc_pkg::OFS_OPT_A, 32'h0);
      check(rd, 32'h2);
      check(hresp, rdpc_pkg::HRESP_OKAY);
      hsize <= 3'b000;
      ahb(1'b1, rdpc_pkg::OFS_OPT_B, 32'h1);
      hsize <= rdpc_pkg::HSIZE_WORD;
      ahb(1'b0, rdpc_pkg::OFS_OPT_B, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 8'h18, 32'h0);
      check(rd, 32'h0);
      $display("test por done");
   endtask
   task automatic t_pins();
      ahb(1'b1, rdpc_pkg::OFS_PULL_EN, 32'h3f);
      ahb(1'b1, rdpc_pkg::OFS_KEYPAD, 32'h50f);
      ahb(1'b1, rdpc_pkg::OFS_OPT_A, 32'h6);
      pa5 <= 1'b0;
      tick(3);
      check(pull, {6'h3a, 6'h05});
      check({fn, irq_lvl}, 6'b010100);
      pa5 <= 1'b1;
      ahb(1'b1, rdpc_pkg::OFS_OPT_A, 32'he);
      ahb(1'b1, rdpc_pkg::OFS_OPT_B, 32'h1);
      dctl_oe <= 1'b1;
      port_oe <= 1'b1;
      tick(2);
      check({pull.up[5], fn.twi_alt, pa4_oe, pa4_out}, 4'b0110);
      ahb(1'b1, rdpc_pkg::OFS_OPT_A, 32'h0);
      tick(2);
      check({fn.pa4_debug, pa4_oe, pa4_out}, 3'b011);
      dctl_oe <= 1'b0;
      port_oe <= 1'b0;
      ahb(1'b1, rdpc_pkg::OFS_OPT_A, 32'h2);
      ahb(1'b1, rdpc_pkg::OFS_OPT_B, 32'h0);
      $display("test pins done");
   endtask
   task automatic t_bit(input logic v);
      int n;
      tick(20);
      bit_val <= v;
      bit_req <= 1'b1;
      tick(1);
      bit_req <= 1'b0;
      n = 0;
      while (bsmp !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         n++;
      end
      n = 0;
      while (bend !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         n++;
      end
      check(n, 8);
      check(rxb, v);
      $display("test bit done");
   endtask
   task automatic t_force(input logic low);
      mode_low <= low;
      ahb(1'b1, rdpc_pkg::OFS_FORCE, 32'h1);
      wait_rst();
      mode_low <= 1'b0;
      tick(4);
      check(halt, low);
      ahb(1'b0, rdpc_pkg::OFS_STATUS, 32'h0);
      check(rd, {28'h0000000, 3'b010, low});
      $display("test force done");
   endtask
   task automatic t_pin();
      ahb(1'b1, rdpc_pkg::OFS_OPT_A, 32'h3);
      ahb(1'b1, rdpc_pkg::OFS_OPT_A, 32'h0);
      tick(2);
      ahb(1'b0, rdpc_pkg::OFS_OPT_A, 32'h0);
      check({pull.up[5], rd}, {1'b1, 32'h1});
      mode_low <= 1'b1;
      pa5 <= 1'b0;
      tick(5);
      pa5 <= 1'b1;
      wait_rst();
      mode_low <= 1'b0;
      check(halt, 0);
      ahb(1'b0, rdpc_pkg::OFS_OPT_A, 32'h0);
      check(rd, 32'h3);
      ahb(1'b0, rdpc_pkg::OFS_STATUS, 32'h0);
      check(rd, 32'h2);
      $display("test pin reset done");
   endtask
   // watchdog
   initial begin
      #250000;
      errors++;
      final_report();
   end
   initial begin
      i_rstn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = rdpc_pkg::HSIZE_WORD;
      hwdata = 32'h0;
      pa5 = 1'b1;
      dctl_out = 1'b0;
      dctl_oe = 1'b0;
      port_out = 1'b1;
      port_oe = 1'b0;
      mode_low = 1'b0;
      bit_req = 1'b0;
      bit_val = 1'b0;
      t_por();
      t_pins();
      t_bit(1'b1);
      t_bit(1'b0);
      t_force(1'b0);
      t_force(1'b1);
      t_pin();
      t_por();
      final_report();
   end
endmodule
